// *** core/iaf_pkg.sv ***
`default_nettype none
package iaf_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int IAF_ADDR_W    = 12;
  localparam int IAF_DATA_W    = 32;
  localparam int IAF_MATCH_W   = 128;
  localparam int IAF_V4_W      = 32;
  localparam int IAF_CAP_BYTES = 32;
  localparam int IAF_CAP_W     = IAF_CAP_BYTES * 8;
  localparam int IAF_MAX_FLOWS = 8;
  localparam int IAF_MAX_CH    = 8;
  localparam int IAF_WORDS     = IAF_MATCH_W / IAF_DATA_W;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] IAF_REG_CTRL   = 12'h000;
  localparam logic [11:0] IAF_REG_STATUS = 12'h004;
  localparam logic [5:0]  IAF_SUB_CFG    = 6'h00;
  localparam logic [5:0]  IAF_SUB_MATCH  = 6'h10;
  localparam logic [5:0]  IAF_SUB_MASK   = 6'h20;
  localparam int IAF_BLK_LSB  = 6;
  localparam int IAF_WORD_LSB = 2;

  // control word fields
  localparam int IAF_CTRL_MODE_LSB = 0;
  localparam int IAF_CTRL_ZERO_BIT = 2;
  localparam int IAF_CTRL_FIX_BIT  = 3;
  localparam int IAF_CTRL_POS_LSB  = 8;
  localparam int IAF_CTRL_LEN_LSB  = 16;
  localparam int IAF_CTRL_FPOS_LSB = 18;
  localparam int IAF_CTRL_SIG_LSB  = 24;
  // flow config word fields
  localparam int IAF_FCFG_EN_BIT   = 0;
  localparam int IAF_FCFG_SEL_LSB  = 1;
  localparam int IAF_FCFG_CH_LSB   = 8;
  // status word fields
  localparam int IAF_STAT_HIT_LSB  = 0;
  localparam int IAF_STAT_CONF_BIT = 8;

  localparam logic [1:0] IAF_LEN_RST = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IAF_MODE_IPV4  = 2'h0,
    IAF_MODE_IPV6  = 2'h1,
    IAF_MODE_OTH32 = 2'h2,
    IAF_MODE_OTH128 = 2'h3
  } iaf_mode_t;

  typedef enum logic [1:0] {
    IAF_SEL_SRC    = 2'h0,
    IAF_SEL_DST    = 2'h1,
    IAF_SEL_EITHER = 2'h2,
    IAF_SEL_RSVD   = 2'h3
  } iaf_sel_t;

  typedef struct packed {
    iaf_mode_t   mode;
    logic        zeroEn;
    logic        fixEn;
    logic [7:0]  csumPos;
    logic [1:0]  csumLen;
    logic [4:0]  flowPos;
    logic [4:0]  sigPos;
  } iaf_ctrl_t;

  typedef struct packed {
    logic        enable;
    iaf_sel_t    addrSel;
    logic [7:0]  chanEn;
    logic [127:0] value;
    logic [127:0] mask;
  } iaf_flow_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [2:0] chan;
    logic [7:0] data;
  } iaf_hdr_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] hits;
    logic       zeroEn;
    logic       fixEn;
    logic [7:0] csumPos;
    logic [1:0] csumLen;
    logic [4:0] sigPos;
  } iaf_res_t;

  // masked compare: only bits with mask one take part
  function automatic logic iaf_masked_eq(input logic [127:0] field,
                                         input logic [127:0] value,
                                         input logic [127:0] mask);
    return ((field ^ value) & mask) == '0;
  endfunction : iaf_masked_eq

endpackage : iaf_pkg
`default_nettype wire

// *** core/iaf_flow_match.sv ***
`default_nettype none
module iaf_flow_match
  import iaf_pkg::*;
(
  input  wire iaf_flow_cfg_t          cfg,
  input  wire iaf_mode_t              mode,
  input  wire logic [IAF_CAP_W-1:0]   field,
  input  wire logic [2:0]             chan,
  output logic                        hit
);

  // ----------------------------------------------------------------
  // field slices, first captured byte in the top bits
  // ----------------------------------------------------------------
  localparam int V4_PAD = IAF_MATCH_W - IAF_V4_W;

  wire logic [127:0] src128  = field[IAF_CAP_W-1 -: IAF_MATCH_W];
  wire logic [127:0] dst128  = field[IAF_MATCH_W-1:0];
  wire logic [127:0] src32   = {field[IAF_CAP_W-1 -: IAF_V4_W], {V4_PAD{1'b0}}};
  wire logic [127:0] dst32   = {field[IAF_CAP_W-IAF_V4_W-1 -: IAF_V4_W],
                                {V4_PAD{1'b0}}};
  wire logic [127:0] mask32  = {cfg.mask[IAF_MATCH_W-1 -: IAF_V4_W],
                                {V4_PAD{1'b0}}};
  wire logic         narrow  = (mode == IAF_MODE_IPV4) || (mode == IAF_MODE_OTH32);
  wire logic         ipMode  = (mode == IAF_MODE_IPV4) || (mode == IAF_MODE_IPV6);
  wire logic [127:0] useMask = narrow ? mask32 : cfg.mask;

  wire logic srcHit = iaf_masked_eq(narrow ? src32 : src128, cfg.value, useMask);
  wire logic dstHit = iaf_masked_eq(narrow ? dst32 : dst128, cfg.value, useMask);

  // ----------------------------------------------------------------
  // address selection and enables
  // ----------------------------------------------------------------
  wire logic ipHit = (cfg.addrSel == IAF_SEL_SRC)    ? srcHit :
                     (cfg.addrSel == IAF_SEL_DST)    ? dstHit :
                     (cfg.addrSel == IAF_SEL_EITHER) ? (srcHit | dstHit) : 1'b0;
  wire logic fieldHit = ipMode ? ipHit : srcHit;
  wire logic gate     = cfg.enable & cfg.chanEn[chan];

  assign hit = gate & fieldHit;

endmodule : iaf_flow_match
`default_nettype wire

// *** core/iaf_flow_verify.sv ***
//
// Contract
// - With the zero enable set, the checksum-length bytes of the header from the checksum position are replaced by zeroes.
// - With the fix enable set, the later rewriter is told to patch the last two payload bytes.
// - The 8-bit checksum position is handed downstream so the rewriter finds the checksum.
// - The 2-bit checksum length sets how many bytes are located and zeroed.
// - In IPv4 or IPv6 mode a flow matches on source, destination or either address.
// - In other modes a 32- or 128-bit field at the flow position is matched.
// - A flow applies on a channel only when its enable and that channel enable are set.
// - The address select picks 0 source, 1 destination, 2 either.
// - In IPv4 mode only the upper 32 bits of the match value are compared.
// - A mask bit of one makes its match bit count, zero makes it ignored.
// - The 5-bit signature position marks the field used for the frame signature.
// - The protocol select picks 0 IPv4, 1 IPv6, 2 other 32-bit, 3 other 128-bit.
`default_nettype none
module iaf_flow_verify
  import iaf_pkg::*;
#(
  parameter int NUM_FLOWS    = 2,
  parameter int NUM_CHANNELS = 2
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic [IAF_ADDR_W-1:0] regAddr,
  input  wire logic [IAF_DATA_W-1:0] regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [IAF_DATA_W-1:0] regRdata,
  input  wire iaf_hdr_t              hdrIn,
  output var  iaf_hdr_t              hdrOut,
  output var  iaf_res_t              result
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (NUM_FLOWS < 1 || NUM_FLOWS > IAF_MAX_FLOWS) begin : g_bad_flows
    $error("NUM_FLOWS out of range");
  end
  if (NUM_CHANNELS < 1 || NUM_CHANNELS > IAF_MAX_CH) begin : g_bad_ch
    $error("NUM_CHANNELS out of range");
  end

  localparam logic [7:0] CAP_LIMIT = 8'(IAF_CAP_BYTES);
  localparam logic [7:0] CH_MASK   = 8'((1 << NUM_CHANNELS) - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  iaf_ctrl_t     ctrl_r;
  iaf_flow_cfg_t flowCfg_r [NUM_FLOWS];
  logic [7:0]    byteIdx_r;
  logic [7:0]    capBytes_r [IAF_CAP_BYTES];
  logic          evalPending_r;
  logic [2:0]    evalChan_r;
  logic [7:0]    lastHits_r;
  logic [IAF_DATA_W-1:0] rdata_r;
  iaf_hdr_t      hdrOut_r;
  iaf_res_t      result_r;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic [5:0] blk_of(input logic [IAF_ADDR_W-1:0] a);
    return a[IAF_ADDR_W-1:IAF_BLK_LSB];
  endfunction : blk_of

  function automatic logic [5:0] sub_of(input logic [IAF_ADDR_W-1:0] a);
    return {a[IAF_BLK_LSB-1:IAF_WORD_LSB+2], 4'h0};
  endfunction : sub_of

  wire logic [5:0] regBlk   = blk_of(regAddr);
  wire logic [5:0] regSub   = sub_of(regAddr);
  wire logic [1:0] regWord  = regAddr[IAF_WORD_LSB +: 2];
  wire logic       flowArea = (regBlk != 6'h00) && (regBlk <= 6'(NUM_FLOWS));
  wire logic [5:0] flowIdx  = regBlk - 6'h01;
  wire logic       wrCtrl   = regWr && (regAddr == IAF_REG_CTRL);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r         <= '0;
      ctrl_r.csumLen <= IAF_LEN_RST;
    end else if (wrCtrl) begin
      ctrl_r.mode    <= iaf_mode_t'(regWdata[IAF_CTRL_MODE_LSB +: 2]);
      ctrl_r.zeroEn  <= regWdata[IAF_CTRL_ZERO_BIT];
      ctrl_r.fixEn   <= regWdata[IAF_CTRL_FIX_BIT];
      ctrl_r.csumPos <= regWdata[IAF_CTRL_POS_LSB +: 8];
      ctrl_r.csumLen <= regWdata[IAF_CTRL_LEN_LSB +: 2];
      ctrl_r.flowPos <= regWdata[IAF_CTRL_FPOS_LSB +: 5];
      ctrl_r.sigPos  <= regWdata[IAF_CTRL_SIG_LSB +: 5];
    end
  end

  wire logic [IAF_DATA_W-1:0] ctrlWord = {
    3'h0, ctrl_r.sigPos, 1'b0, ctrl_r.flowPos, ctrl_r.csumLen,
    ctrl_r.csumPos, 4'h0, ctrl_r.fixEn, ctrl_r.zeroEn, ctrl_r.mode};

  // is the software's duty; a clash is only reported
  wire logic cfgClash = ctrl_r.zeroEn & ctrl_r.fixEn;

  // ----------------------------------------------------------------
  // per-flow registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int f = 0; f < NUM_FLOWS; f++) begin
        flowCfg_r[f] <= '0;
      end
    end else if (regWr && flowArea) begin
      for (int f = 0; f < NUM_FLOWS; f++) begin
        if (flowIdx == 6'(f)) begin
          if (regSub == IAF_SUB_CFG && regWord == 2'h0) begin
            flowCfg_r[f].enable  <= regWdata[IAF_FCFG_EN_BIT];
            flowCfg_r[f].addrSel <= iaf_sel_t'(regWdata[IAF_FCFG_SEL_LSB +: 2]);
            flowCfg_r[f].chanEn  <= regWdata[IAF_FCFG_CH_LSB +: 8] & CH_MASK;
          end
          if (regSub == IAF_SUB_MATCH) begin
            flowCfg_r[f].value[regWord*IAF_DATA_W +: IAF_DATA_W] <= regWdata;
          end
          if (regSub == IAF_SUB_MASK) begin
            flowCfg_r[f].mask[regWord*IAF_DATA_W +: IAF_DATA_W] <= regWdata;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  iaf_flow_cfg_t rdFlow;
  logic [IAF_DATA_W-1:0] rdNxt;

  always_comb begin
    rdFlow = '0;
    for (int f = 0; f < NUM_FLOWS; f++) begin
      if (flowIdx == 6'(f)) begin
        rdFlow = flowCfg_r[f];
      end
    end
  end

  wire logic [IAF_DATA_W-1:0] statWord = {
    23'h0, cfgClash, lastHits_r};
  wire logic [IAF_DATA_W-1:0] fcfgWord = {
    16'h0, rdFlow.chanEn, 5'h0, rdFlow.addrSel, rdFlow.enable};
  wire logic [IAF_DATA_W-1:0] valWord  =
    rdFlow.value[regWord*IAF_DATA_W +: IAF_DATA_W];
  wire logic [IAF_DATA_W-1:0] mskWord  =
    rdFlow.mask[regWord*IAF_DATA_W +: IAF_DATA_W];

  always_comb begin
    rdNxt = '0;
    if (regAddr == IAF_REG_CTRL) begin
      rdNxt = ctrlWord;
    end else if (regAddr == IAF_REG_STATUS) begin
      rdNxt = statWord;
    end else if (flowArea) begin
      if (regSub == IAF_SUB_CFG && regWord == 2'h0) begin
        rdNxt = fcfgWord;
      end else if (regSub == IAF_SUB_MATCH) begin
        rdNxt = valWord;
      end else if (regSub == IAF_SUB_MASK) begin
        rdNxt = mskWord;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= regRd ? rdNxt : '0;
    end
  end

  assign regRdata = rdata_r;

  // ----------------------------------------------------------------
  // header byte position
  // ----------------------------------------------------------------
  wire logic [7:0] flowPos8 = {3'h0, ctrl_r.flowPos};
  wire logic [7:0] relIdx   = byteIdx_r - flowPos8;
  wire logic       inWin    = hdrIn.valid && (byteIdx_r >= flowPos8) &&
                              (relIdx < CAP_LIMIT);
  wire logic [7:0] csumRel  = byteIdx_r - ctrl_r.csumPos;
  wire logic       zeroHit  = hdrIn.valid && ctrl_r.zeroEn &&
                              (byteIdx_r >= ctrl_r.csumPos) &&
                              (csumRel < {6'h0, ctrl_r.csumLen});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      byteIdx_r <= '0;
    end else if (hdrIn.valid) begin
      if (hdrIn.last) begin
        byteIdx_r <= '0;
      end else if (byteIdx_r != 8'hff) begin
        byteIdx_r <= byteIdx_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // field capture, cleared once a result is taken
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < IAF_CAP_BYTES; i++) begin
        capBytes_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < IAF_CAP_BYTES; i++) begin
        if (inWin && relIdx[4:0] == 5'(i)) begin
          capBytes_r[i] <= hdrIn.data;
        end else if (evalPending_r) begin
          capBytes_r[i] <= '0;
        end
      end
    end
  end

  logic [IAF_CAP_W-1:0] capField;

  always_comb begin
    capField = '0;
    for (int i = 0; i < IAF_CAP_BYTES; i++) begin
      capField[IAF_CAP_W-1-8*i -: 8] = capBytes_r[i];
    end
  end

  // ----------------------------------------------------------------
  // flow comparators
  // ----------------------------------------------------------------
  logic [7:0] flowHits;

  for (genvar f = 0; f < IAF_MAX_FLOWS; f++) begin : g_flow
    if (f < NUM_FLOWS) begin : g_on
      iaf_flow_match u_match (
        .cfg   (flowCfg_r[f]),
        .mode  (ctrl_r.mode),
        .field (capField),
        .chan  (evalChan_r),
        .hit   (flowHits[f])
      );
    end else begin : g_off
      assign flowHits[f] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // byte pass-through with checksum zeroing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hdrOut_r <= '0;
    end else begin
      hdrOut_r.valid <= hdrIn.valid;
      hdrOut_r.last  <= hdrIn.valid & hdrIn.last;
      hdrOut_r.chan  <= hdrIn.chan;
      hdrOut_r.data  <= zeroHit ? 8'h00 : hdrIn.data;
    end
  end

  assign hdrOut = hdrOut_r;

  // ----------------------------------------------------------------
  // verdict and downstream hand-off
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evalPending_r <= 1'b0;
      evalChan_r    <= '0;
    end else begin
      evalPending_r <= hdrIn.valid & hdrIn.last;
      if (hdrIn.valid & hdrIn.last) begin
        evalChan_r <= hdrIn.chan;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r   <= '0;
      lastHits_r <= '0;
    end else begin
      result_r.valid <= evalPending_r;
      if (evalPending_r) begin
        result_r.hits    <= flowHits;
        result_r.zeroEn  <= ctrl_r.zeroEn;
        result_r.fixEn   <= ctrl_r.fixEn;
        result_r.csumPos <= ctrl_r.csumPos;
        result_r.csumLen <= ctrl_r.csumLen;
        result_r.sigPos  <= ctrl_r.sigPos;
        lastHits_r       <= flowHits;
      end
    end
  end

  assign result = result_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  zero_byte_a: assert property (zeroHit |=> hdrOut.data == 8'h00)
    else $error("checksum byte not zeroed");
  pass_byte_a: assert property (hdrIn.valid && !zeroHit |=> hdrOut.data == $past(hdrIn.data))
    else $error("header byte altered");
  zero_span_a: assert property (hdrIn.valid && ctrl_r.zeroEn &&
      byteIdx_r >= ctrl_r.csumPos && byteIdx_r < ctrl_r.csumPos + 9'(ctrl_r.csumLen)
      |=> hdrOut.data == 8'h00)
    else $error("checksum span byte not zeroed");
  fix_flag_a: assert property (result.valid |-> result.fixEn == $past(ctrl_r.fixEn))
    else $error("fix enable not handed on");
  csum_pos_a: assert property (result.valid |-> result.csumPos == $past(ctrl_r.csumPos))
    else $error("checksum position not handed on");
  sig_pos_a: assert property (result.valid |-> result.sigPos == $past(ctrl_r.sigPos))
    else $error("signature position not handed on");
  verdict_time_a: assert property (hdrIn.valid && hdrIn.last |-> ##2 result.valid)
    else $error("verdict not two cycles after last byte");
  flow_gate_a: assert property (result.valid && result.hits[0] |->
      $past(flowCfg_r[0].enable) && $past(flowCfg_r[0].chanEn[evalChan_r]))
    else $error("hit on disabled flow or channel");
  read_ctrl_a: assert property (regRd && regAddr == IAF_REG_CTRL |=> regRdata == $past(ctrlWord))
    else $error("control read mismatch");

  zero_seen_c:  cover property (zeroHit);
  hit_seen_c:   cover property (result.valid && result.hits != 8'h00);
  clash_seen_c: cover property (cfgClash && result.valid);

endmodule : iaf_flow_verify
`default_nettype wire

// *** test/iaf_hdr_src.sv ***
`default_nettype none
module iaf_hdr_src
  import iaf_pkg::*;
(
  input  wire logic     clk,
  output var  iaf_hdr_t hdrIn
);
  timeunit 1ns;
  timeprecision 1ns;

  initial hdrIn = '0;

  // ----------------------------------------------------------------
  // header byte source, one byte per cycle
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] bytes[$], input logic [2:0] ch);
    int lastIdx;
    lastIdx = bytes.size() - 1;
    for (int i = 0; i <= lastIdx; i++) begin
      @(posedge clk);
      hdrIn <= '{valid: 1'b1, last: (i == lastIdx), chan: ch, data: bytes[i]};
    end
    @(posedge clk);
    // released stream shows inverted values so stale bytes never look real
    hdrIn <= '{valid: 1'b0, last: 1'b0, chan: ~ch, data: ~bytes[lastIdx]};
  endtask : send
endmodule : iaf_hdr_src
`default_nettype wire

// *** test/tb_ip_ach_flow_verify.sv ***
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_ip_ach_flow_verify
  import iaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  clk      = 1'b0;
  logic                  arst_n   = 1'b0;
  logic [IAF_ADDR_W-1:0] regAddr  = '0;
  logic [IAF_DATA_W-1:0] regWdata = '0;
  logic                  regWr    = 1'b0;
  logic                  regRd    = 1'b0;
  logic [IAF_DATA_W-1:0] regRdata;
  iaf_hdr_t              hdrIn;
  iaf_hdr_t              hdrOut;
  iaf_res_t              result;
  int                    bad_count = 0;
  int                    samples_checked = 0;
  int                    cycles = 0;
  int                    mode, fp, ch, zero, fix, cpos, clen, sig, n;
  logic [31:0]           seed = 32'h5d1cd2ff;
  logic [31:0]           ctrlW;
  logic [8:0]            curExp;
  logic [8:0]            expQ[$];
  logic [7:0]            hb[$];
  logic [7:0]            hexp;
  logic                  en[2];
  logic [1:0]            sel[2];
  logic [7:0]            che[2];
  logic [127:0]          val[2], msk[2], wm, wf;
  logic [16:0]           infoE;

  always #25 clk = ~clk;

  iaf_flow_verify u_iaf_flow_verify (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .hdrIn(hdrIn), .hdrOut(hdrOut), .result(result)
  );
  iaf_hdr_src u_iaf_hdr_src (.clk(clk), .hdrIn(hdrIn));

  // ----------------------------------------------------------------
  // helpers and reference model
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
    return seed;
  endfunction : rnd

  // n bytes from flow position plus base, first byte at the top
  function automatic logic [127:0] fld(input int base, input int nb);
    logic [127:0] r;
    r = '0;
    for (int k = 0; k < nb; k++) r[127-8*k -: 8] = hb[fp+base+k];
    return r;
  endfunction : fld

  function automatic logic hitOf(input int f);
    int nb;
    logic s, d;
    nb = (mode % 2 == 0) ? 4 : 16;
    s = ((fld(0, nb) ^ val[f]) & msk[f] & wm) == '0;
    d = ((fld(nb, nb) ^ val[f]) & msk[f] & wm) == '0;
    if (mode < 2) s = (sel[f] == 0) ? s : (sel[f] == 1) ? d : (sel[f] == 2) ? (s | d) : 1'b0;
    return en[f] && ch < 2 && che[f][ch] && s;
  endfunction : hitOf

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK(nm, e, regRdata)
    @(posedge clk);
    #1 `CHK("rdata idle", 32'h0, regRdata)
  endtask : rdChk

  // ----------------------------------------------------------------
  // output stream monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (hdrOut.valid === 1'b1) begin
      curExp = (expQ.size() > 0) ? expQ.pop_front() : 9'h1ff;
      `CHK("hdrOut", curExp, {hdrOut.last, hdrOut.data})
      `CHK("hdrOut chan", 3'(ch), hdrOut.chan)
    end
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rdChk("ctrl reset", IAF_REG_CTRL, 32'h00020000);
    rdChk("status reset", IAF_REG_STATUS, 32'h0);
    rdChk("flow reset", 12'h040, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 24; r++) begin
      hb.delete();
      repeat (40) hb.push_back(8'(rnd()));
      mode = r % 4;
      fp   = int'(rnd() % 8);
      ch   = int'(rnd() % 4);
      zero = int'(rnd() % 2);
      fix  = zero ? 0 : int'(rnd() % 2);
      cpos = int'(rnd() % 40);
      clen = int'(rnd() % 4);
      sig  = int'(rnd() % 32);
      wm   = (mode % 2 == 0) ? {32'hffffffff, 96'h0} : '1;
      ctrlW = {3'h0, 5'(sig), 1'b0, 5'(fp), 2'(clen), 8'(cpos), 4'h0, 1'(fix), 1'(zero),
               2'(mode)};
      wr(IAF_REG_CTRL, ctrlW);
      for (int f = 0; f < 2; f++) begin
        en[f]  = (rnd() % 4) != 0;
        sel[f] = 2'(rnd());
        che[f] = 8'(rnd());
        val[f] = {rnd(), rnd(), rnd(), rnd()};
        wf = fld(f * ((mode % 2 == 0) ? 4 : 16), 16);
        if (rnd() % 4 != 0) val[f] = (wf & wm) | (val[f] & ~wm);
        msk[f] = (rnd() % 2) ? '1 : {rnd(), rnd(), rnd(), rnd()};
        wr(12'(64 * (f + 1)), {16'h0, che[f], 5'h0, sel[f], en[f]});
        for (int w = 0; w < 4; w++) begin
          wr(12'(64 * (f + 1) + 16 + 4 * w), val[f][32*w +: 32]);
          wr(12'(64 * (f + 1) + 32 + 4 * w), msk[f][32*w +: 32]);
        end
      end
      rdChk("ctrl", IAF_REG_CTRL, ctrlW);
      rdChk("flow cfg", 12'h040, {16'h0, che[0] & 8'h03, 5'h0, sel[0], en[0]});
      for (int i = 0; i < 40; i++)
        expQ.push_back({i == 39, (zero && i >= cpos && i < cpos + clen) ? 8'h0 : hb[i]});
      u_iaf_hdr_src.send(hb, 3'(ch));
      n = 0;
      do begin
        @(posedge clk);
        #1 n++;
      end while (result.valid !== 1'b1 && n < 8);
      hexp = {6'h0, hitOf(1), hitOf(0)};
      `CHK("latency", 1, n)
      `CHK("hits", hexp, result.hits)
      infoE = {1'(zero), 1'(fix), 8'(cpos), 2'(clen), 5'(sig)};
      `CHK("info", infoE, result[16:0])
      rdChk("status", IAF_REG_STATUS, {24'h0, hexp});
    end
    $display("test frames done");
    wr(12'h0c0, 32'hffffffff);
    rdChk("unmapped flow", 12'h0c0, 32'h0);
    rdChk("unmapped", 12'h008, 32'h0);
    `CHK("leftover bytes", 0, expQ.size())
    $display("test unmapped done");
    report_and_stop();
  end
endmodule : tb_ip_ach_flow_verify
`default_nettype wire
